/* File: inc/region_checker_pkg.sv */
package region_checker_pkg;

  // Transaction address and the compared slice of it
  localparam int unsigned TXN_ADDR_W = 40;
  localparam int unsigned CMP_LSB = 8;
  localparam int unsigned CMP_W = 32;

  // Configuration port address map
  localparam int unsigned CFG_ADDR_W = 16;
  localparam int unsigned REGION_SHIFT = 8;
  localparam logic [1:0] FLD_START = 2'h0;
  localparam logic [1:0] FLD_END = 2'h1;
  localparam logic [1:0] FLD_MASTERS = 2'h2;
  localparam logic [1:0] FLD_CONFIG = 2'h3;
  localparam logic [15:0] OFF_START = 16'h0000;
  localparam logic [15:0] OFF_END = 16'h0004;
  localparam logic [15:0] OFF_MASTERS = 16'h0008;
  localparam logic [15:0] OFF_CONFIG = 16'h000c;
  localparam logic [15:0] OFF_CTRL = 16'h1000;
  localparam logic [15:0] OFF_SINK = 16'h1004;
  localparam logic [15:0] OFF_STATUS = 16'h1008;
  localparam logic [15:0] OFF_ENABLED = 16'h100c;

  // Region master allow register
  localparam int unsigned MASTERS_W = 31;
  localparam logic [30:0] MASTERS_RESET = 31'h00000004;
  localparam int unsigned ALLOW_PLATFORM_MANAGER = 2;
  localparam int unsigned ALLOW_APPLICATION_CLUSTER = 18;

  // Region config register fields
  localparam int unsigned CONFIG_W = 6;
  localparam int unsigned CFG_ENABLE = 0;
  localparam int unsigned CFG_READ_PERMIT = 1;
  localparam int unsigned CFG_WRITE_PERMIT = 2;
  localparam int unsigned CFG_NONSECURE = 3;
  localparam int unsigned CFG_STRICT = 4;
  localparam int unsigned CFG_SKIP_ID = 5;
  localparam logic [5:0] CONFIG_RESET = 6'h06;
  localparam logic [31:0] START_RESET = 32'h00000000;
  localparam logic [31:0] END_RESET = 32'h00000000;

  // Control register fields
  localparam int unsigned CTRL_W = 4;
  localparam int unsigned CTRL_UNMATCHED_READ = 0;
  localparam int unsigned CTRL_UNMATCHED_WRITE = 1;
  localparam int unsigned CTRL_POISON_ATTR = 2;
  localparam int unsigned CTRL_POISON_ADDR = 3;
  localparam logic [3:0] CTRL_RESET = 4'h3;

  localparam logic [31:0] SINK_RESET = 32'h00800000;

  // Sticky violation status
  localparam int unsigned STAT_W = 4;
  localparam int unsigned STAT_READ = 1;
  localparam int unsigned STAT_WRITE = 2;
  localparam int unsigned STAT_SECURITY = 3;
  localparam logic [3:0] STAT_RESET = 4'h0;

  localparam int unsigned PROT_NONSECURE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: hdl/checked_addr_stage.sv */
// Registered address channel stage; applies poisoning on the way through
module checked_addr_stage #(
  parameter int unsigned ID_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [region_checker_pkg::TXN_ADDR_W-1:0] inAddr,
  input wire logic [2:0] inProt,
  input wire logic [ID_W-1:0] inUser,
  input wire logic inValid,
  output logic inReady,
  input wire logic [region_checker_pkg::STAT_W-1:0] violation,
  input wire logic poisonByAttr,
  input wire logic poisonByAddr,
  input wire logic [31:0] sinkBase,
  output logic [region_checker_pkg::TXN_ADDR_W-1:0] outAddr,
  output logic [2:0] outProt,
  output logic [ID_W-1:0] outUser,
  output logic outValid,
  input wire logic outReady,
  output logic [region_checker_pkg::STAT_W-1:0] takenViolation
);

  logic take;
  logic poisoned;

  assign inReady = !outValid || outReady;
  assign take = inValid && inReady;
  assign poisoned = |violation;
  assign takenViolation = take ? violation : '0;

  always_ff @(posedge clk) begin
    if (rst) begin
      outValid <= 1'b0;
    end else if (inReady) begin
      outValid <= inValid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      outAddr <= '0;
      outProt <= '0;
      outUser <= '0;
    end else if (take) begin
      outUser <= inUser;
      outAddr <= inAddr;
      outProt <= inProt;
      if (poisoned && poisonByAddr) begin
        outAddr <= {sinkBase,
          inAddr[region_checker_pkg::CMP_LSB-1:0]};
      end
      if (poisoned && poisonByAttr) begin
        outProt[region_checker_pkg::PROT_NONSECURE] <= 1'b1;
      end
    end
  end

endmodule

/* File: hdl/pl_region_access_checker.sv */
// Contract
// - Requester ID checked against region mask; unauthorized poisoned.
// - Master mask holds bits 0..30, one per master group; bit 31 zero.
// - Platform manager bit 2 resets to one; other mask bits to zero.
// - Inside an enabled region, direction permit is checked first.
// - ID security check only runs when the direction is permitted.
// - Overlapping regions: any poisoning region poisons the transaction.
// - ID check on: secure only if ID in mask; off: prot bit low secure.
// - Config bit 4: zero relaxed, one strict nonsecure region check.
// - Non-secure request reaches only non-secure regions, else poisoned.
// - Config bit 3: zero secure region, one non-secure; resets zero.
// - Write permit bit 2 resets one; zero poisons writes to region.
// - Read permit bit 1 resets one; zero poisons reads to region.
// - Enable bit 0 resets zero; disabled region ignored entirely.
// - Requester ID comes from the AXI user sideband, forwarded downstream unchanged.
// - Attribute poisoning without address swap forces prot bit 1 high.
// - Unmatched read and write permits are both set after reset.
// - Bounds compare against address bits 39:8.
// - Missing all regions poisons when the unmatched permit is zero.
// - Address swap puts sink base on bits 39:8, keeps bits 7:0.
// - Only the first violation is recorded in sticky status.
module pl_region_access_checker #(
  parameter int unsigned NUM_REGIONS = 16,
  parameter int unsigned ID_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  // Configuration port
  input wire logic [region_checker_pkg::CFG_ADDR_W-1:0] cfgAwaddr,
  input wire logic cfgAwvalid,
  output logic cfgAwready,
  input wire logic [31:0] cfgWdata,
  input wire logic [3:0] cfgWstrb,
  input wire logic cfgWvalid,
  output logic cfgWready,
  output logic [1:0] cfgBresp,
  output logic cfgBvalid,
  input wire logic cfgBready,
  input wire logic [region_checker_pkg::CFG_ADDR_W-1:0] cfgAraddr,
  input wire logic cfgArvalid,
  output logic cfgArready,
  output logic [31:0] cfgRdata,
  output logic [1:0] cfgRresp,
  output logic cfgRlast,
  output logic cfgRvalid,
  input wire logic cfgRready,
  // Upstream write address
  input wire logic [region_checker_pkg::TXN_ADDR_W-1:0] sAwaddr,
  input wire logic [2:0] sAwprot,
  input wire logic [ID_W-1:0] sAwuser,
  input wire logic sAwvalid,
  output logic sAwready,
  // Upstream read address
  input wire logic [region_checker_pkg::TXN_ADDR_W-1:0] sAraddr,
  input wire logic [2:0] sArprot,
  input wire logic [ID_W-1:0] sAruser,
  input wire logic sArvalid,
  output logic sArready,
  // Downstream write address
  output logic [region_checker_pkg::TXN_ADDR_W-1:0] mAwaddr,
  output logic [2:0] mAwprot,
  output logic [ID_W-1:0] mAwuser,
  output logic mAwvalid,
  input wire logic mAwready,
  // Downstream read address
  output logic [region_checker_pkg::TXN_ADDR_W-1:0] mAraddr,
  output logic [2:0] mArprot,
  output logic [ID_W-1:0] mAruser,
  output logic mArvalid,
  input wire logic mArready
);

  localparam int unsigned CMP_W = region_checker_pkg::CMP_W;
  localparam int unsigned MW = region_checker_pkg::MASTERS_W;
  localparam int unsigned CW = region_checker_pkg::CONFIG_W;
  localparam int unsigned SW = region_checker_pkg::STAT_W;

  if (NUM_REGIONS < 1 || NUM_REGIONS > 16) begin : g_bad_regions
    $error("NUM_REGIONS must lie in 1..16");
  end
  if (ID_W < 1 || ID_W > 8) begin : g_bad_id
    $error("ID_W must lie in 1..8");
  end

  logic [CMP_W-1:0] startQ [NUM_REGIONS];
  logic [CMP_W-1:0] endQ [NUM_REGIONS];
  logic [MW-1:0] mastersQ [NUM_REGIONS];
  logic [CW-1:0] configQ [NUM_REGIONS];
  logic [region_checker_pkg::CTRL_W-1:0] ctrlQ;
  logic [31:0] sinkQ;
  logic [SW-1:0] statusQ;
  logic [SW-1:0] statusD;
  logic [4:0] enabledCount;

  logic wrGo;
  logic rdGo;
  logic wrMapped;
  logic [1:0] bRespQ;
  logic bValidQ;
  logic [31:0] rDataQ;
  logic [1:0] rRespQ;
  logic rValidQ;
  logic [31:0] rdValue;

  logic [SW-1:0] awViolation;
  logic [SW-1:0] arViolation;
  logic [SW-1:0] awTaken;
  logic [SW-1:0] arTaken;

  // True when the address selects one of the region register words
  function automatic logic inRegionSpace(
    input logic [region_checker_pkg::CFG_ADDR_W-1:0] a
  );
    logic ok;
    ok = (a[15:12] == 4'h0) && (a[7:4] == 4'h0) &&
      (32'(a[11:8]) < NUM_REGIONS);
    return ok;
  endfunction

  // Any register word at all, used by both read and write decode
  function automatic logic isMapped(
    input logic [region_checker_pkg::CFG_ADDR_W-1:0] a
  );
    logic [15:0] w;
    w = {a[15:2], 2'b00};
    return inRegionSpace(a) ||
      w == region_checker_pkg::OFF_CTRL ||
      w == region_checker_pkg::OFF_SINK ||
      w == region_checker_pkg::OFF_STATUS ||
      w == region_checker_pkg::OFF_ENABLED;
  endfunction

  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] nw,
    input logic [3:0] strb
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Judges one request against all regions; returns status-shaped flags
  function automatic logic [SW-1:0] judge(
    input logic [region_checker_pkg::TXN_ADDR_W-1:0] a,
    input logic isWrite,
    input logic [2:0] prot,
    input logic [ID_W-1:0] id
  );
    logic [SW-1:0] v;
    logic anyHit;
    logic nsReq;
    logic idOk;
    logic dirOk;
    logic secOk;
    logic [CMP_W-1:0] key;
    v = '0;
    anyHit = 1'b0;
    nsReq = prot[region_checker_pkg::PROT_NONSECURE];
    key = a[region_checker_pkg::TXN_ADDR_W-1:region_checker_pkg::CMP_LSB];
    for (int i = 0; i < NUM_REGIONS; i++) begin
      if (configQ[i][region_checker_pkg::CFG_ENABLE] &&
          key >= startQ[i] && key <= endQ[i]) begin
        anyHit = 1'b1;
        dirOk = isWrite ?
          configQ[i][region_checker_pkg::CFG_WRITE_PERMIT] :
          configQ[i][region_checker_pkg::CFG_READ_PERMIT];
        // Mask bit picked by the sideband index; out-of-range IDs match none
        idOk = configQ[i][region_checker_pkg::CFG_SKIP_ID] ||
          ((32'(id) < MW) && mastersQ[i][id]);
        if (configQ[i][region_checker_pkg::CFG_NONSECURE]) begin
          secOk = nsReq ||
            !configQ[i][region_checker_pkg::CFG_STRICT];
        end else begin
          secOk = !nsReq;
        end
        if (!dirOk) begin
          if (isWrite) begin
            v[region_checker_pkg::STAT_WRITE] = 1'b1;
          end else begin
            v[region_checker_pkg::STAT_READ] = 1'b1;
          end
        end else if (!(idOk && secOk)) begin
          v[region_checker_pkg::STAT_SECURITY] = 1'b1;
        end
      end
    end
    if (!anyHit) begin
      if (isWrite &&
          !ctrlQ[region_checker_pkg::CTRL_UNMATCHED_WRITE]) begin
        v[region_checker_pkg::STAT_WRITE] = 1'b1;
      end
      if (!isWrite &&
          !ctrlQ[region_checker_pkg::CTRL_UNMATCHED_READ]) begin
        v[region_checker_pkg::STAT_READ] = 1'b1;
      end
    end
    return v;
  endfunction

  // Write side: address and data taken together, one beat per write
  assign wrGo = cfgAwvalid && cfgWvalid && !bValidQ;
  assign cfgAwready = wrGo;
  assign cfgWready = wrGo;
  assign wrMapped = isMapped(cfgAwaddr);
  assign cfgBresp = bRespQ;
  assign cfgBvalid = bValidQ;

  always_ff @(posedge clk) begin
    if (rst) begin
      bValidQ <= 1'b0;
      bRespQ <= region_checker_pkg::RESP_OKAY;
    end else if (wrGo) begin
      bValidQ <= 1'b1;
      bRespQ <= wrMapped ? region_checker_pkg::RESP_OKAY :
        region_checker_pkg::RESP_SLVERR;
    end else if (cfgBready) begin
      bValidQ <= 1'b0;
    end
  end

  for (genvar i = 0; i < NUM_REGIONS; i++) begin : g_region
    logic hit;
    assign hit = wrGo && inRegionSpace(cfgAwaddr) &&
      (32'(cfgAwaddr[11:8]) == i);
    always_ff @(posedge clk) begin
      if (rst) begin
        startQ[i] <= region_checker_pkg::START_RESET;
        endQ[i] <= region_checker_pkg::END_RESET;
        mastersQ[i] <= region_checker_pkg::MASTERS_RESET;
        configQ[i] <= region_checker_pkg::CONFIG_RESET;
      end else if (hit) begin
        case (cfgAwaddr[3:2])
          region_checker_pkg::FLD_START: begin
            startQ[i] <= mergeBytes(startQ[i], cfgWdata, cfgWstrb);
          end
          region_checker_pkg::FLD_END: begin
            endQ[i] <= mergeBytes(endQ[i], cfgWdata, cfgWstrb);
          end
          region_checker_pkg::FLD_MASTERS: begin
            mastersQ[i] <= MW'(mergeBytes({1'b0, mastersQ[i]},
              cfgWdata, cfgWstrb));
          end
          region_checker_pkg::FLD_CONFIG: begin
            configQ[i] <= CW'(mergeBytes({26'h0, configQ[i]},
              cfgWdata, cfgWstrb));
          end
          default: begin
            startQ[i] <= startQ[i];
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrlQ <= region_checker_pkg::CTRL_RESET;
      sinkQ <= region_checker_pkg::SINK_RESET;
    end else if (wrGo) begin
      if ({cfgAwaddr[15:2], 2'b00} == region_checker_pkg::OFF_CTRL) begin
        ctrlQ <= region_checker_pkg::CTRL_W'(mergeBytes(
          {28'h0, ctrlQ}, cfgWdata, cfgWstrb));
      end
      if ({cfgAwaddr[15:2], 2'b00} == region_checker_pkg::OFF_SINK) begin
        sinkQ <= mergeBytes(sinkQ, cfgWdata, cfgWstrb);
      end
    end
  end

  // Sticky status: record only while clear, a same-cycle clear does not admit the event
  always_comb begin
    logic [SW-1:0] clr;
    logic [SW-1:0] ev;
    clr = '0;
    ev = (statusQ == '0) ? (awTaken | arTaken) : '0;
    if (wrGo && cfgWstrb[0] &&
        {cfgAwaddr[15:2], 2'b00} == region_checker_pkg::OFF_STATUS) begin
      clr = cfgWdata[SW-1:0];
    end
    statusD = ((statusQ & ~clr) | ev) & 4'he;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      statusQ <= region_checker_pkg::STAT_RESET;
    end else begin
      statusQ <= statusD;
    end
  end

  always_comb begin
    enabledCount = '0;
    for (int i = 0; i < NUM_REGIONS; i++) begin
      enabledCount = enabledCount +
        5'(configQ[i][region_checker_pkg::CFG_ENABLE]);
    end
  end

  // Read side
  assign rdGo = cfgArvalid && !rValidQ;
  assign cfgArready = rdGo;
  assign cfgRdata = rDataQ;
  assign cfgRresp = rRespQ;
  assign cfgRvalid = rValidQ;
  assign cfgRlast = rValidQ;

  always_comb begin
    logic [3:0] r;
    r = cfgAraddr[11:8];
    rdValue = 32'h0;
    if (inRegionSpace(cfgAraddr)) begin
      case (cfgAraddr[3:2])
        region_checker_pkg::FLD_START: rdValue = startQ[r];
        region_checker_pkg::FLD_END: rdValue = endQ[r];
        region_checker_pkg::FLD_MASTERS: rdValue = {1'b0, mastersQ[r]};
        region_checker_pkg::FLD_CONFIG: rdValue = {26'h0, configQ[r]};
        default: rdValue = 32'h0;
      endcase
    end else begin
      case ({cfgAraddr[15:2], 2'b00})
        region_checker_pkg::OFF_CTRL: rdValue = {28'h0, ctrlQ};
        region_checker_pkg::OFF_SINK: rdValue = sinkQ;
        region_checker_pkg::OFF_STATUS: rdValue = {28'h0, statusQ};
        region_checker_pkg::OFF_ENABLED: rdValue = {27'h0, enabledCount};
        default: rdValue = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rValidQ <= 1'b0;
      rDataQ <= 32'h0;
      rRespQ <= region_checker_pkg::RESP_OKAY;
    end else if (rdGo) begin
      rValidQ <= 1'b1;
      rDataQ <= rdValue;
      rRespQ <= isMapped(cfgAraddr) ? region_checker_pkg::RESP_OKAY :
        region_checker_pkg::RESP_SLVERR;
    end else if (cfgRready) begin
      rValidQ <= 1'b0;
    end
  end

  // Requests judged on the upstream side, ID from the user sideband
  assign awViolation = judge(sAwaddr, 1'b1, sAwprot, sAwuser);
  assign arViolation = judge(sAraddr, 1'b0, sArprot, sAruser);

  checked_addr_stage #(.ID_W(ID_W)) writeStage (
    .clk(clk),
    .rst(rst),
    .inAddr(sAwaddr),
    .inProt(sAwprot),
    .inUser(sAwuser),
    .inValid(sAwvalid),
    .inReady(sAwready),
    .violation(awViolation),
    .poisonByAttr(ctrlQ[region_checker_pkg::CTRL_POISON_ATTR]),
    .poisonByAddr(ctrlQ[region_checker_pkg::CTRL_POISON_ADDR]),
    .sinkBase(sinkQ),
    .outAddr(mAwaddr),
    .outProt(mAwprot),
    .outUser(mAwuser),
    .outValid(mAwvalid),
    .outReady(mAwready),
    .takenViolation(awTaken)
  );

  checked_addr_stage #(.ID_W(ID_W)) readStage (
    .clk(clk),
    .rst(rst),
    .inAddr(sAraddr),
    .inProt(sArprot),
    .inUser(sAruser),
    .inValid(sArvalid),
    .inReady(sArready),
    .violation(arViolation),
    .poisonByAttr(ctrlQ[region_checker_pkg::CTRL_POISON_ATTR]),
    .poisonByAddr(ctrlQ[region_checker_pkg::CTRL_POISON_ADDR]),
    .sinkBase(sinkQ),
    .outAddr(mAraddr),
    .outProt(mArprot),
    .outUser(mAruser),
    .outValid(mArvalid),
    .outReady(mArready),
    .takenViolation(arTaken)
  );

endmodule

/* File: test/region_checker_properties.sv */
module region_checker_properties #(
  parameter int unsigned ID_W = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] cfgAraddr,
  input wire logic cfgArvalid,
  input wire logic cfgRvalid,
  input wire logic [31:0] cfgRdata,
  input wire logic [39:0] sAwaddr,
  input wire logic [2:0] sAwprot,
  input wire logic [ID_W-1:0] sAwuser,
  input wire logic sAwvalid,
  input wire logic sAwready,
  input wire logic [2:0] sArprot,
  input wire logic [ID_W-1:0] sAruser,
  input wire logic sArvalid,
  input wire logic sArready,
  input wire logic [39:0] mAwaddr,
  input wire logic [2:0] mAwprot,
  input wire logic [ID_W-1:0] mAwuser,
  input wire logic mAwvalid,
  input wire logic mAwready,
  input wire logic [2:0] mArprot,
  input wire logic [ID_W-1:0] mAruser,
  input wire logic mArvalid
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence aw_taken;
    sAwvalid && sAwready;
  endsequence
  sequence ar_taken;
    sArvalid && sArready;
  endsequence
  sequence mask_read;
    cfgArvalid && !cfgRvalid && cfgAraddr[15:12] == 4'h0
      && cfgAraddr[7:0] == 8'h08;
  endsequence
  a_aw_forward_next: assert property (aw_taken |=> mAwvalid)
    else $error("write address not forwarded next cycle");
  a_ar_forward_next: assert property (ar_taken |=> mArvalid)
    else $error("read address not forwarded next cycle");
  a_aw_user_kept: assert property (aw_taken |=>
    mAwuser == $past(sAwuser))
    else $error("write requester id changed");
  a_ar_user_kept: assert property (ar_taken |=>
    mAruser == $past(sAruser))
    else $error("read requester id changed");
  a_low_bits_kept: assert property (aw_taken |=>
    mAwaddr[7:0] == $past(sAwaddr[7:0]))
    else $error("low address byte changed");
  a_prot_rest_kept: assert property (ar_taken |=>
    mArprot[0] == $past(sArprot[0]) && mArprot[2] == $past(sArprot[2]))
    else $error("read protection bits changed");
  a_nonsecure_kept: assert property (aw_taken ##0 sAwprot[1] |=>
    mAwprot[1])
    else $error("non-secure write made secure");
  a_aw_stall_hold: assert property (mAwvalid && !mAwready |=>
    mAwvalid && $stable(mAwaddr) && $stable(mAwprot))
    else $error("stalled write address not held");
  a_mask_top_zero: assert property (mask_read |=> !cfgRdata[31])
    else $error("mask bit 31 reads one");
endmodule

bind pl_region_access_checker region_checker_properties #(.ID_W(ID_W)) chk (
  .clk, .rst, .cfgAraddr, .cfgArvalid, .cfgRvalid, .cfgRdata, .sAwaddr,
  .sAwprot, .sAwuser, .sAwvalid, .sAwready, .sArprot, .sAruser, .sArvalid,
  .sArready, .mAwaddr, .mAwprot, .mAwuser, .mAwvalid, .mAwready, .mArprot,
  .mAruser, .mArvalid);

/* File: test/addr_sink_model.sv */
module addr_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic valid,
  input wire logic [39:0] addr,
  input wire logic [2:0] prot,
  output logic ready,
  output logic [39:0] gotAddr_q,
  output logic [2:0] gotProt_q,
  output logic [7:0] gotCnt_q
);
  timeunit 1ns;
  timeprecision 100ps;
  logic phase_q;
  always_ff @(posedge clk) begin
    phase_q <= rst ? 1'b0 : !phase_q;
  end
  // Slow mode accepts every other cycle to exercise stalls
  assign ready = !slow || phase_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      gotCnt_q <= 8'h00;
    end else if (valid && ready) begin
      gotAddr_q <= addr;
      gotProt_q <= prot;
      gotCnt_q <= gotCnt_q + 8'h01;
    end
  end
endmodule

/* File: test/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, slow = 0;
  logic [15:0] cfgAwaddr = '0, cfgAraddr = '0;
  logic [31:0] cfgWdata = '0, cfgRdata;
  logic [3:0] cfgWstrb = 4'hf, ctrlMode = 4'h3;
  logic cfgAwvalid = 0, cfgWvalid = 0, cfgBready = 1, cfgArvalid = 0;
  logic cfgRready = 1, cfgAwready, cfgWready, cfgBvalid, cfgArready;
  logic cfgRlast, cfgRvalid, sAwvalid = 0, sArvalid = 0, sAwready;
  logic sArready, mAwvalid, mArvalid, mAwready, mArready;
  logic [1:0] cfgBresp, cfgRresp;
  logic [39:0] sAwaddr = '0, sAraddr = '0, mAwaddr, mAraddr, gotAw, gotAr;
  logic [2:0] sAwprot = '0, sArprot = '0, mAwprot, mArprot, gotAwp, gotArp;
  logic [4:0] sAwuser = '0, sAruser = '0, mAwuser, mAruser;
  logic [7:0] cntAw, cntAr;
  // Readies as the design saw them at the last edge
  logic [3:0] rdySeen = '0;
  int nMismatch = 0, checksDone = 0;
  always #4 clk = ~clk;
  pl_region_access_checker uut (.clk, .rst, .cfgAwaddr, .cfgAwvalid,
    .cfgAwready, .cfgWdata, .cfgWstrb, .cfgWvalid, .cfgWready, .cfgBresp,
    .cfgBvalid, .cfgBready, .cfgAraddr, .cfgArvalid, .cfgArready, .cfgRdata,
    .cfgRresp, .cfgRlast, .cfgRvalid, .cfgRready, .sAwaddr, .sAwprot,
    .sAwuser, .sAwvalid, .sAwready, .sAraddr, .sArprot, .sAruser, .sArvalid,
    .sArready, .mAwaddr, .mAwprot, .mAwuser, .mAwvalid, .mAwready, .mAraddr,
    .mArprot, .mAruser, .mArvalid, .mArready);
  addr_sink_model awSink (.clk, .rst, .slow, .valid(mAwvalid),
    .addr(mAwaddr), .prot(mAwprot), .ready(mAwready), .gotAddr_q(gotAw),
    .gotProt_q(gotAwp), .gotCnt_q(cntAw));
  addr_sink_model arSink (.clk, .rst, .slow, .valid(mArvalid),
    .addr(mAraddr), .prot(mArprot), .ready(mArready), .gotAddr_q(gotAr),
    .gotProt_q(gotArp), .gotCnt_q(cntAr));
  task automatic close_out;
    $display("mismatches %0d checks %0d", nMismatch, checksDone);
    if (nMismatch == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(string m);
    nMismatch++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(logic [39:0] got, logic [39:0] exp, string m);
    checksDone++;
    if (got !== exp) fail(m);
  endtask
  task automatic tick(int n);
    if (n == 20) begin
      fail("handshake timeout");
      close_out;
    end else begin
      @(posedge clk);
      rdySeen = {cfgAwready, cfgArready, sAwready, sArready};
      #1;
    end
  endtask
  task automatic wr(logic [15:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
    int n = 0;
    {cfgAwaddr, cfgWdata, cfgAwvalid, cfgWvalid} = {a, d, 2'b11};
    do tick(n++); while (!rdySeen[3]);
    {cfgAwvalid, cfgWvalid} = 2'b00;
    chk({cfgBvalid, cfgBresp}, {1'b1, r}, "write response");
    tick(0);
  endtask
  task automatic rchk(logic [15:0] a, logic [31:0] d, logic [1:0] r = 2'h0);
    int n = 0;
    {cfgAraddr, cfgArvalid} = {a, 1'b1};
    do tick(n++); while (!rdySeen[2]);
    cfgArvalid = 0;
    chk({cfgRvalid, cfgRlast, cfgRresp, cfgRdata}, {2'b11, r, d},
      "read data");
    tick(0);
  endtask
  task automatic ctl(logic [3:0] m);
    ctrlMode = m;
    wr(16'h1000, {28'h0, m});
  endtask
  task automatic send(bit w, logic [39:0] a, logic [2:0] p, logic [4:0] u,
                      bit bad);
    logic [7:0] c0;
    logic [39:0] ea;
    logic [2:0] ep;
    int n = 0;
    c0 = w ? cntAw : cntAr;
    ea = bad && ctrlMode[3] ? {region_checker_pkg::SINK_RESET, a[7:0]} : a;
    ep = bad && ctrlMode[2] ? p | 3'h2 : p;
    if (w) {sAwaddr, sAwprot, sAwuser, sAwvalid} = {a, p, u, 1'b1};
    else {sAraddr, sArprot, sAruser, sArvalid} = {a, p, u, 1'b1};
    do tick(n++); while (!(w ? rdySeen[1] : rdySeen[0]));
    {sAwvalid, sArvalid} = 2'b00;
    n = 0;
    while ((w ? cntAw : cntAr) == c0) tick(n++);
    chk(w ? gotAw : gotAr, ea, "forwarded address");
    chk({37'h0, w ? gotAwp : gotArp}, {37'h0, ep}, "forwarded protection");
  endtask
  task automatic s_reset;
    rchk(16'h0008, 32'h4);
    rchk(16'h0f0c, 32'h6);
    rchk(16'h1000, 32'h3);
    wr(16'h0108, 32'hffffffff);
    rchk(16'h0108, 32'h7fffffff);
    rchk(16'h1010, 32'h0, 2'h2);
  endtask
  task automatic s_permit;
    ctl(4'hf);
    wr(16'h0000, 32'h10);
    wr(16'h0004, 32'h10);
    wr(16'h0008, 32'h8);
    wr(16'h000c, 32'h1);
    send(1, 40'h1044, 3'h0, 5'd3, 1);
    send(0, 40'h10ff, 3'h0, 5'd3, 1);
    wr(16'h000c, 32'h7);
    rchk(16'h100c, 32'h1);
    send(1, 40'h1000, 3'h0, 5'd3, 0);
    send(0, 40'h10ff, 3'h0, 5'd4, 1);
    send(1, 40'h1100, 3'h0, 5'd4, 0);
    wr(16'h000c, 32'h6);
    send(0, 40'h1010, 3'h0, 5'd4, 0);
  endtask
  task automatic s_secure;
    slow = 1;
    wr(16'h000c, 32'h27);
    send(1, 40'h1020, 3'h0, 5'd4, 0);
    send(1, 40'h1020, 3'h2, 5'd4, 1);
    wr(16'h000c, 32'h0f);
    send(0, 40'h1020, 3'h0, 5'd3, 0);
    send(0, 40'h1020, 3'h2, 5'd3, 0);
    wr(16'h000c, 32'h1f);
    send(0, 40'h1020, 3'h0, 5'd3, 1);
    wr(16'h0008, 32'h40000);
    wr(16'h000c, 32'h7);
    send(1, 40'h1020, 3'h0, 5'd18, 0);
    slow = 0;
  endtask
  task automatic s_overlap;
    wr(16'h0100, 32'h10);
    wr(16'h0104, 32'h10);
    wr(16'h010c, 32'h3);
    send(0, 40'h1030, 3'h0, 5'd18, 0);
    send(1, 40'h1030, 3'h0, 5'd18, 1);
  endtask
  task automatic s_unmatched;
    ctl(4'hd);
    send(1, 40'h5000, 3'h0, 5'd1, 1);
    send(0, 40'h5000, 3'h0, 5'd1, 0);
    ctl(4'h6);
    send(0, 40'h5008, 3'h1, 5'd1, 1);
  endtask
  task automatic s_status;
    wr(16'h1008, 32'he);
    rchk(16'h1008, 32'h0);
    send(0, 40'h5010, 3'h0, 5'd1, 1);
    rchk(16'h1008, 32'h2);
    send(1, 40'h1030, 3'h0, 5'd18, 1);
    rchk(16'h1008, 32'h2);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst = 0;
    s_reset();
    s_permit();
    s_secure();
    s_overlap();
    s_unmatched();
    s_status();
    close_out();
  end
endmodule
